/* inc/ehcfg_pkg.sv */
// Package of constants for the extended hypervisor configuration register block
package ehcfg_pkg;
    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int unsigned BIT_MSC_EN     = 11;
    localparam int unsigned BIT_MCE_CTRL   = 10;
    localparam int unsigned BIT_CMO_WPERM  = 9;
    localparam int unsigned BIT_VFIQ_SP    = 8;
    localparam int unsigned BIT_VIRQ_SP    = 7;
    localparam int unsigned BIT_TRAP_MASK  = 6;
    localparam int unsigned BIT_SPRIO_MAP  = 5;
    localparam int unsigned BIT_FGT_QUAL   = 4;
    localparam int unsigned BIT_XS_BEHAV   = 3;
    localparam int unsigned BIT_TRAP_STST  = 2;
    localparam int unsigned BIT_TRAP_WLS   = 1;
    localparam int unsigned BIT_TRAP_STACC = 0;
    localparam int unsigned IMPL_BITS      = 12;

    // ---------------------------------------------------------------
    // Values after reset and codes
    // ---------------------------------------------------------------
    localparam logic [11:0] RESET_VALUE    = 12'h000;
    localparam logic [7:0]  NV_MEM_SLOT    = 8'hA0;
    localparam logic [5:0]  EC_SYSREG      = 6'h18;
    localparam logic [5:0]  EC_WIDE_LS     = 6'h0A;
    localparam logic [24:0] ISS_STST       = 25'h0000000;
    localparam logic [24:0] ISS_STACC      = 25'h0000001;
    localparam logic [24:0] ISS_WLS        = 25'h0000002;

    // Exception levels
    typedef enum logic [1:0] {
        EHCFG_EL0 = 2'b00,
        EHCFG_EL1 = 2'b01,
        EHCFG_EL2 = 2'b10,
        EHCFG_EL3 = 2'b11
    } ehcfg_el_t;

    // Outcome of a system register access
    typedef enum logic [2:0] {
        EHCFG_ACC_OK    = 3'b000,
        EHCFG_ACC_UNDEF = 3'b001,
        EHCFG_ACC_TRAP2 = 3'b010,
        EHCFG_ACC_TRAP3 = 3'b011,
        EHCFG_ACC_NESTED_VIRT_MEMORY_PAGE = 3'b100,
        EHCFG_ACC_RAZ   = 3'b101
    } ehcfg_acc_t;

    // Wide load/store instruction kinds
    typedef enum logic [1:0] {
        EHCFG_WIDE_NONE  = 2'b00,
        EHCFG_WIDE_LS    = 2'b01,
        EHCFG_WIDE_STST  = 2'b10,
        EHCFG_WIDE_STACC = 2'b11
    } ehcfg_wide_t;
endpackage : ehcfg_pkg

/* src/ehcfg_sync.sv */
// Two-stage synchroniser for a single level
module ehcfg_sync (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ce,
    input  wire logic din,
    output logic      dout
);
    logic meta_reg;

    // ---------------------------------------------------------------
    // Capture chain, first stage read only by second
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= 1'b0;
            dout     <= 1'b0;
        end else if (ce) begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end
endmodule : ehcfg_sync

/* src/ehcfg_top.sv */
// Extended hypervisor configuration register with access and trap decode
// Functional notes
// RL1: Controls act zero unless level 2 enabled
// RL2: No level 2: whole register reads zero
// RL3: Bit 11 copy/set enable, forced one
// RL4: Bit 10 ignored in host mode pair
// RL5: Bit 9 cache maintenance write permission
// RL6: Bit 8 needs virtual fast pending
// RL7: Bit 7 needs virtual normal pending
// RL8: Bit 6 traps mask writes, class 0x18
// RL9: Bit 5 zero without streaming priority
// RL10: Bit 4 fine traps cover qualifier
// RL11: Bit 3 extended-sync behaviour and barrier
// RL12: Bits 9, 3 may be TLB cached
// RL13: Bit 2 traps store-with-status, syndrome 0
// RL14: Bit 1 traps wide load/store, syndrome 2
// RL15: Bit 0 traps accumulated store, syndrome 1
// RL16: Warm reset clears bits 8..0 except 5; reset here loads RESET_VALUE, clearing all bits 11..0
// RL17: Level 1 access: slot, trap, undefined
// RL18: Level 2 access may trap to 3
// RL19: Upper and absent-feature bits read zero
module ehcfg_top
    import ehcfg_pkg::*;
#(
    parameter bit HAVE_EL2      = 1'b1,
    parameter bit HAVE_EL3      = 1'b1,
    parameter bit HAVE_MOPS     = 1'b1,
    parameter bit HAVE_CACHE_MAINT_WRITE_PERM     = 1'b1,
    parameter bit HAVE_NMI      = 1'b1,
    parameter bit HAVE_SME      = 1'b1,
    parameter bit HAVE_XS       = 1'b1,
    parameter bit HAVE_LS64_V   = 1'b1,
    parameter bit HAVE_LS64     = 1'b1,
    parameter bit HAVE_LS64_ACC = 1'b1
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    // System register access port
    input  wire logic        acc_valid,
    input  wire logic        acc_write,
    input  wire logic [1:0]  acc_el,
    input  wire logic [63:0] acc_wdata,
    output logic             acc_done,
    output logic [2:0]       acc_result,
    output logic [63:0]      acc_rdata,
    output logic [5:0]       acc_ec,
    output logic [7:0]       nested_virt_memory_page_slot,
    // Context state from the core
    input  wire logic        el2_enabled,
    input  wire logic        top_level_reg_enable,
    input  wire logic        host_mode_bit,
    input  wire logic        trap_general_bit,
    input  wire logic        nested_virt_bit,
    input  wire logic        nested_virt_mem_bit,
    input  wire logic        virt_fiq_pending,
    input  wire logic        virt_irq_pending,
    input  wire logic        halted,
    input  wire logic        secure_debug_disable,
    input  wire logic        el3_trap_prio_sdd,
    input  wire logic        streaming_prio_supported,
    // Instruction check port
    input  wire logic        insn_valid,
    input  wire logic [1:0]  insn_el,
    input  wire logic [1:0]  insn_wide,
    input  wire logic        insn_mask_write,
    input  wire logic        insn_stage2_access_perm1,
    input  wire logic        insn_dirty_bit_modifier,
    output logic             insn_trap,
    output logic [5:0]       insn_ec,
    output logic [24:0]      insn_iss,
    output logic             cmo_write_ok,
    // Effective controls
    output logic             mem_copy_set_enable,
    output logic             mem_copy_exception_ctrl,
    output logic             cache_maint_write_perm,
    output logic             virt_fast_irq_superprio,
    output logic             virt_norm_irq_superprio,
    output logic             trap_mask_state_write,
    output logic             streaming_prio_map_enable,
    output logic             fine_trap_qualifier_apply,
    output logic             extended_sync_behaviour,
    output logic             trap_store_with_status,
    output logic             trap_wide_load_store,
    output logic             trap_store_accum_data
);
    // ---------------------------------------------------------------
    // Reset release
    // ---------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_sync_b;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_reg <= 1'b0;
            rst_sync_b   <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_b   <= rst_meta_reg;
        end
    end

    // Halt status is a pin from the debug domain
    logic halted_s;
    ehcfg_sync u_halt_sync (
        .clk   (clk),
        .rst_b (rst_sync_b),
        .ce    (ce),
        .din   (halted),
        .dout  (halted_s)
    );

    // ---------------------------------------------------------------
    // Implemented bit mask
    // ---------------------------------------------------------------
    logic [11:0] impl_mask;
    always_comb begin
        impl_mask                 = 12'h000;
        impl_mask[BIT_MSC_EN]     = HAVE_MOPS;
        impl_mask[BIT_MCE_CTRL]   = HAVE_MOPS;
        impl_mask[BIT_CMO_WPERM]  = HAVE_CACHE_MAINT_WRITE_PERM;
        impl_mask[BIT_VFIQ_SP]    = HAVE_NMI;
        impl_mask[BIT_VIRQ_SP]    = HAVE_NMI;
        impl_mask[BIT_TRAP_MASK]  = HAVE_NMI;
        impl_mask[BIT_SPRIO_MAP]  = HAVE_SME & streaming_prio_supported; // RL9
        impl_mask[BIT_FGT_QUAL]   = HAVE_XS;
        impl_mask[BIT_XS_BEHAV]   = HAVE_XS;
        impl_mask[BIT_TRAP_STST]  = HAVE_LS64_V;
        impl_mask[BIT_TRAP_WLS]   = HAVE_LS64;
        impl_mask[BIT_TRAP_STACC] = HAVE_LS64_ACC;
        // Without level 2 nothing is implemented
        if (!HAVE_EL2) begin
            impl_mask = 12'h000; // RL2
        end
    end

    // ---------------------------------------------------------------
    // Access decode
    // ---------------------------------------------------------------
    logic [2:0] acc_kind;
    logic [5:0] acc_kind_ec;
    logic       el3_block;
    always_comb begin
        acc_kind    = EHCFG_ACC_UNDEF;
        acc_kind_ec = 6'h00;
        el3_block   = HAVE_EL3 && !top_level_reg_enable;
        case (acc_el)
            EHCFG_EL0: begin
                acc_kind = EHCFG_ACC_UNDEF; // RL17
            end
            EHCFG_EL1: begin
                if (el2_enabled && nested_virt_mem_bit && nested_virt_bit) begin
                    acc_kind = EHCFG_ACC_NESTED_VIRT_MEMORY_PAGE; // RL17
                end else if (el2_enabled && nested_virt_bit) begin
                    acc_kind    = EHCFG_ACC_TRAP2; // RL17
                    acc_kind_ec = EC_SYSREG;
                end else begin
                    acc_kind = EHCFG_ACC_UNDEF;
                end
            end
            EHCFG_EL2: begin
                if (halted_s && secure_debug_disable && el3_trap_prio_sdd && el3_block) begin
                    acc_kind = EHCFG_ACC_UNDEF; // RL18
                end else if (el3_block) begin
                    if (halted_s && secure_debug_disable) begin
                        acc_kind = EHCFG_ACC_UNDEF; // RL18
                    end else begin
                        acc_kind    = EHCFG_ACC_TRAP3; // RL18
                        acc_kind_ec = EC_SYSREG;
                    end
                end else begin
                    acc_kind = EHCFG_ACC_OK;
                end
            end
            EHCFG_EL3: begin
                acc_kind = HAVE_EL2 ? EHCFG_ACC_OK : EHCFG_ACC_RAZ; // RL2
            end
            default: begin
                acc_kind = EHCFG_ACC_UNDEF;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Stored register
    // ---------------------------------------------------------------
    logic [11:0] cfg_reg;
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            cfg_reg <= RESET_VALUE; // RL16
        end else if (ce && acc_valid && acc_write && acc_kind == EHCFG_ACC_OK) begin
            cfg_reg <= acc_wdata[11:0] & impl_mask; // RL19
        end
    end

    // Answer status of an access, trap class beside it
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            acc_done   <= 1'b0;
            acc_result <= EHCFG_ACC_UNDEF;
            acc_ec     <= 6'h00;
        end else if (ce) begin
            acc_done   <= acc_valid;
            acc_result <= acc_kind;
            acc_ec     <= acc_kind_ec; // RL18
        end
    end

    // Memory slot of a redirected nested access
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            nested_virt_memory_page_slot <= 8'h00;
        end else if (ce) begin
            nested_virt_memory_page_slot <= (acc_kind == EHCFG_ACC_NESTED_VIRT_MEMORY_PAGE) ? NV_MEM_SLOT : 8'h00; // RL17
        end
    end

    // Read data, zero unless a granted read
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            acc_rdata <= 64'h0000000000000000;
        end else if (ce) begin
            if (acc_valid && !acc_write && acc_kind == EHCFG_ACC_OK) begin
                acc_rdata <= {52'h0000000000000, cfg_reg & impl_mask}; // RL19
            end else begin
                acc_rdata <= 64'h0000000000000000;
            end
        end
    end

    // ---------------------------------------------------------------
    // Effective values
    // ---------------------------------------------------------------
    logic        live;
    logic        host_pair;
    logic [11:0] eff;
    always_comb begin
        live      = HAVE_EL2 && el2_enabled && top_level_reg_enable;
        host_pair = host_mode_bit && trap_general_bit;
        eff       = live ? (cfg_reg & impl_mask) : 12'h000; // RL1
        if (HAVE_MOPS && (!live || host_pair)) begin
            eff[BIT_MSC_EN] = 1'b1; // RL3
        end
        // Host pair hands these controls to level 2 system control
        if (host_pair) begin
            eff[BIT_MCE_CTRL] = 1'b0; // RL4
            eff[BIT_TRAP_STST] = 1'b0; // RL13
            eff[BIT_TRAP_WLS] = 1'b0; // RL14
            eff[BIT_TRAP_STACC] = 1'b0; // RL15
        end
        // Superpriority only with a pending virtual interrupt
        eff[BIT_VFIQ_SP] = eff[BIT_VFIQ_SP] & virt_fiq_pending; // RL6
        eff[BIT_VIRQ_SP] = eff[BIT_VIRQ_SP] & virt_irq_pending; // RL7
    end

    // Registered control outputs
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            mem_copy_set_enable       <= 1'b0;
            mem_copy_exception_ctrl   <= 1'b0;
            cache_maint_write_perm    <= 1'b0;
            virt_fast_irq_superprio   <= 1'b0;
            virt_norm_irq_superprio   <= 1'b0;
            trap_mask_state_write     <= 1'b0;
            streaming_prio_map_enable <= 1'b0;
            fine_trap_qualifier_apply <= 1'b0;
            extended_sync_behaviour   <= 1'b0;
            trap_store_with_status    <= 1'b0;
            trap_wide_load_store      <= 1'b0;
            trap_store_accum_data     <= 1'b0;
        end else if (ce) begin
            mem_copy_set_enable       <= eff[BIT_MSC_EN];     // RL3
            mem_copy_exception_ctrl   <= eff[BIT_MCE_CTRL];   // RL4
            cache_maint_write_perm    <= eff[BIT_CMO_WPERM];  // RL12
            virt_fast_irq_superprio   <= eff[BIT_VFIQ_SP];    // RL6
            virt_norm_irq_superprio   <= eff[BIT_VIRQ_SP];    // RL7
            trap_mask_state_write     <= eff[BIT_TRAP_MASK];  // RL8
            streaming_prio_map_enable <= eff[BIT_SPRIO_MAP];  // RL9
            fine_trap_qualifier_apply <= eff[BIT_FGT_QUAL];   // RL10
            extended_sync_behaviour   <= eff[BIT_XS_BEHAV];   // RL11
            trap_store_with_status    <= eff[BIT_TRAP_STST];  // RL13
            trap_wide_load_store      <= eff[BIT_TRAP_WLS];   // RL14
            trap_store_accum_data     <= eff[BIT_TRAP_STACC]; // RL15
        end
    end

    // ---------------------------------------------------------------
    // Instruction trap check
    // ---------------------------------------------------------------
    logic        low_el;
    logic        trap_now;
    logic [5:0]  trap_ec;
    logic [24:0] trap_iss;
    always_comb begin
        low_el   = (insn_el == EHCFG_EL0) || (insn_el == EHCFG_EL1);
        trap_now = 1'b0;
        trap_ec  = 6'h00;
        trap_iss = 25'h0000000;
        if (insn_mask_write && insn_el == EHCFG_EL1 && eff[BIT_TRAP_MASK]) begin
            trap_now = 1'b1; // RL8
            trap_ec  = EC_SYSREG;
        end else if (low_el) begin
            case (insn_wide)
                EHCFG_WIDE_STST: begin
                    trap_now = eff[BIT_TRAP_STST]; // RL13
                    trap_ec  = EC_WIDE_LS;
                    trap_iss = ISS_STST;
                end
                EHCFG_WIDE_LS: begin
                    trap_now = eff[BIT_TRAP_WLS]; // RL14
                    trap_ec  = EC_WIDE_LS;
                    trap_iss = ISS_WLS;
                end
                EHCFG_WIDE_STACC: begin
                    trap_now = eff[BIT_TRAP_STACC]; // RL15
                    trap_ec  = EC_WIDE_LS;
                    trap_iss = ISS_STACC;
                end
                default: begin
                    trap_now = 1'b0;
                end
            endcase
        end
    end

    // Trap answer with class and syndrome
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            insn_trap    <= 1'b0;
            insn_ec      <= 6'h00;
            insn_iss     <= 25'h0000000;
        end else if (ce) begin
            insn_trap    <= insn_valid && trap_now;
            insn_ec      <= (insn_valid && trap_now) ? trap_ec : 6'h00;
            insn_iss     <= (insn_valid && trap_now) ? trap_iss : 25'h0000000;
        end
    end

    // Stage 2 write permission for cache maintenance
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            cmo_write_ok <= 1'b0;
        end else if (ce) begin
            cmo_write_ok <= insn_stage2_access_perm1 | insn_dirty_bit_modifier; // RL5
        end
    end
endmodule : ehcfg_top

/* tb/ehcfg_top_asserts.sv */
// Checker of access decode, trap reporting and effective controls of the configuration register
module ehcfg_top_asserts
    import ehcfg_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        ce,
    input wire logic        acc_valid,
    input wire logic [1:0]  acc_el,
    input wire logic        acc_done,
    input wire logic [2:0]  acc_result,
    input wire logic [63:0] acc_rdata,
    input wire logic [5:0]  acc_ec,
    input wire logic [7:0]  nested_virt_memory_page_slot,
    input wire logic        el2_enabled,
    input wire logic        top_level_reg_enable,
    input wire logic        host_mode_bit,
    input wire logic        trap_general_bit,
    input wire logic        nested_virt_bit,
    input wire logic        nested_virt_mem_bit,
    input wire logic        insn_valid,
    input wire logic [1:0]  insn_wide,
    input wire logic        insn_mask_write,
    input wire logic        insn_stage2_access_perm1,
    input wire logic        insn_dirty_bit_modifier,
    input wire logic        insn_trap,
    input wire logic [24:0] insn_iss,
    input wire logic        cmo_write_ok,
    input wire logic        mem_copy_set_enable,
    input wire logic        trap_store_with_status,
    input wire logic        trap_wide_load_store
);
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    default clocking main_cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    done_follows_req_a: assert property (
        acc_valid && ce |=> acc_done)
        else $error("access answer missing");
    low_level_undef_a: assert property (
        acc_valid && ce && acc_el == 2'b00 |=> acc_result == 3'h1)
        else $error("level 0 access not undefined");
    nested_slot_a: assert property (
        acc_valid && ce && acc_el == 2'b01 && el2_enabled && nested_virt_bit && nested_virt_mem_bit
        |=> acc_result == 3'h4 && nested_virt_memory_page_slot == 8'hA0) else $error("nested access slot wrong");
    top_level_ok_a: assert property (
        acc_valid && ce && acc_el == 2'b11 |=> acc_result == 3'h0)
        else $error("level 3 access refused");
    trap_class_a: assert property (
        acc_done && (acc_result == 3'h2 || acc_result == 3'h3) |-> acc_ec == 6'h18)
        else $error("access trap class wrong");
    upper_bits_zero_a: assert property (
        acc_done |-> acc_rdata[63:12] == 52'h0)
        else $error("upper read bits not zero");
    accum_syndrome_a: assert property (
        insn_valid && ce && insn_wide == 2'b11 && !insn_mask_write |=> !insn_trap || insn_iss == 25'h0000001)
        else $error("accumulated store syndrome wrong");
    cmo_permission_a: assert property (
        insn_valid && ce |=> cmo_write_ok == $past(insn_stage2_access_perm1 | insn_dirty_bit_modifier))
        else $error("maintenance write permission wrong");
    host_pair_a: assert property (
        host_mode_bit && trap_general_bit && ce |=> mem_copy_set_enable && !trap_wide_load_store)
        else $error("host pair not honoured");
    not_live_a: assert property (
        !top_level_reg_enable && ce |=> !trap_store_with_status)
        else $error("control live while disabled");
endmodule : ehcfg_top_asserts

bind ehcfg_top ehcfg_top_asserts ehcfg_top_asserts_i (.*);

/* tb/testbench.sv */
// Self-checking bench for the extended hypervisor configuration register block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // Stimulus and observation
    // ---------------------------------------------------------------
    logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, acc_valid = 1'b0, acc_write = 1'b0, el2_enabled = 1'b1;
    logic top_level_reg_enable = 1'b1, host_mode_bit = 1'b0, trap_general_bit = 1'b0, halted = 1'b0;
    logic nested_virt_bit = 1'b0, nested_virt_mem_bit = 1'b0, virt_fiq_pending = 1'b1, virt_irq_pending = 1'b1;
    logic secure_debug_disable = 1'b0, el3_trap_prio_sdd = 1'b0, streaming_prio_supported = 1'b1;
    logic insn_valid = 1'b0, insn_mask_write = 1'b0, insn_stage2_access_perm1 = 1'b0, insn_dirty_bit_modifier = 1'b0;
    logic [1:0] acc_el = 2'b00, insn_el = 2'b00, insn_wide = 2'b00;
    logic [63:0] acc_wdata = 64'h0, acc_rdata;
    logic acc_done, insn_trap, cmo_write_ok, mem_copy_set_enable, mem_copy_exception_ctrl, cache_maint_write_perm;
    logic virt_fast_irq_superprio, virt_norm_irq_superprio, trap_mask_state_write, streaming_prio_map_enable;
    logic fine_trap_qualifier_apply, extended_sync_behaviour, trap_store_with_status, trap_wide_load_store;
    logic trap_store_accum_data;
    logic [2:0] acc_result;
    logic [5:0] acc_ec, insn_ec;
    logic [7:0] nested_virt_memory_page_slot;
    logic [24:0] insn_iss;
    int num_errors = 0;
    int n_checks = 0;

    ehcfg_top ehcfg_top_i (.*);

    // Free-running clock
    always #5 clk = ~clk;

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One register access, answer looked at half a cycle after the rising edge that takes it
    task automatic acc(input logic wr, input logic [1:0] el, input logic [63:0] wd, input logic [2:0] res,
                       input logic [63:0] rd);
        @(negedge clk);
        acc_valid = 1'b1;
        acc_write = wr;
        acc_el = el;
        acc_wdata = wd;
        @(negedge clk);
        acc_valid = 1'b0;
        chk("acc_done", 64'h1, 64'(acc_done));
        chk("acc_result", 64'(res), 64'(acc_result));
        if (!wr) chk("acc_rdata", rd, acc_rdata);
        chk("acc_ec", (res == 3'h2 || res == 3'h3) ? 64'h18 : 64'h0, 64'(acc_ec));
        chk("nested_virt_memory_page_slot", (res == 3'h4) ? 64'hA0 : 64'h0, 64'(nested_virt_memory_page_slot));
    endtask : acc

    // One instruction check
    task automatic ins(input logic [1:0] el, input logic [1:0] kind, input logic mw, input logic tr,
                       input logic [5:0] ec, input logic [24:0] iss);
        @(negedge clk);
        insn_valid = 1'b1;
        insn_el = el;
        insn_wide = kind;
        insn_mask_write = mw;
        @(negedge clk);
        insn_valid = 1'b0;
        chk("insn_trap", 64'(tr), 64'(insn_trap));
        if (tr) chk("insn_ec", 64'(ec), 64'(insn_ec));
        if (tr && !mw) chk("insn_iss", 64'(iss), 64'(insn_iss));
    endtask : ins

    // Effective controls, bit 11 down to bit 0, after they settle
    task automatic eff(input logic [11:0] exp);
        repeat (2) @(negedge clk);
        chk("effective controls", 64'(exp), 64'({mem_copy_set_enable, mem_copy_exception_ctrl,
            cache_maint_write_perm, virt_fast_irq_superprio, virt_norm_irq_superprio, trap_mask_state_write,
            streaming_prio_map_enable, fine_trap_qualifier_apply, extended_sync_behaviour,
            trap_store_with_status, trap_wide_load_store, trap_store_accum_data}));
    endtask : eff

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done

    // Hang guard, far beyond the 90 or so cycles the tests need
    initial begin
        #20000;
        num_errors++;
        test_done();
    end

    // Main sequence
    initial begin
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        acc(1'b0, 2'd3, 64'h0, 3'h0, 64'h0);
        acc(1'b1, 2'd2, '1, 3'h0, 64'h0);
        acc(1'b0, 2'd2, 64'h0, 3'h0, 64'h0000_0000_0000_0FFF);
        $display("test reset value and field mask done");
        acc(1'b0, 2'd0, 64'h0, 3'h1, 64'h0);
        nested_virt_bit = 1'b1;
        nested_virt_mem_bit = 1'b1;
        acc(1'b0, 2'd1, 64'h0, 3'h4, 64'h0);
        el2_enabled = 1'b0;
        acc(1'b0, 2'd1, 64'h0, 3'h1, 64'h0);
        el2_enabled = 1'b1;
        nested_virt_mem_bit = 1'b0;
        acc(1'b1, 2'd1, 64'h0, 3'h2, 64'h0);
        nested_virt_bit = 1'b0;
        acc(1'b1, 2'd1, 64'h0, 3'h1, 64'h0);
        top_level_reg_enable = 1'b0;
        acc(1'b1, 2'd2, 64'h0, 3'h3, 64'h0);
        halted = 1'b1;
        secure_debug_disable = 1'b1;
        repeat (3) @(negedge clk);
        acc(1'b1, 2'd2, 64'h0, 3'h1, 64'h0);
        el3_trap_prio_sdd = 1'b1;
        acc(1'b0, 2'd2, 64'h0, 3'h1, 64'h0);
        el3_trap_prio_sdd = 1'b0;
        halted = 1'b0;
        secure_debug_disable = 1'b0;
        top_level_reg_enable = 1'b1;
        repeat (3) @(negedge clk);
        acc(1'b0, 2'd3, 64'h0, 3'h0, 64'h0000_0000_0000_0FFF);
        $display("test access decode done");
        eff(12'hFFF);
        ce = 1'b0;
        virt_fiq_pending = 1'b0;
        virt_irq_pending = 1'b0;
        eff(12'hFFF);
        ce = 1'b1;
        eff(12'hE7F);
        virt_fiq_pending = 1'b1;
        virt_irq_pending = 1'b1;
        streaming_prio_supported = 1'b0;
        eff(12'hFDF);
        streaming_prio_supported = 1'b1;
        el2_enabled = 1'b0;
        eff(12'h800);
        el2_enabled = 1'b1;
        top_level_reg_enable = 1'b0;
        eff(12'h800);
        top_level_reg_enable = 1'b1;
        host_mode_bit = 1'b1;
        trap_general_bit = 1'b1;
        eff(12'hBF8);
        ins(2'd0, 2'd1, 1'b0, 1'b0, 6'h00, 25'h0);
        host_mode_bit = 1'b0;
        trap_general_bit = 1'b0;
        $display("test effective controls done");
        ins(2'd0, 2'd2, 1'b0, 1'b1, 6'h0A, 25'h0000000);
        ins(2'd1, 2'd1, 1'b0, 1'b1, 6'h0A, 25'h0000002);
        ins(2'd0, 2'd3, 1'b0, 1'b1, 6'h0A, 25'h0000001);
        ins(2'd1, 2'd0, 1'b1, 1'b1, 6'h18, 25'h0);
        ins(2'd2, 2'd1, 1'b0, 1'b0, 6'h00, 25'h0);
        insn_dirty_bit_modifier = 1'b1;
        ins(2'd1, 2'd0, 1'b0, 1'b0, 6'h00, 25'h0);
        chk("cmo_write_ok", 64'h1, 64'(cmo_write_ok));
        insn_dirty_bit_modifier = 1'b0;
        ins(2'd1, 2'd0, 1'b0, 1'b0, 6'h00, 25'h0);
        chk("cmo_write_ok", 64'h0, 64'(cmo_write_ok));
        insn_stage2_access_perm1 = 1'b1;
        ins(2'd0, 2'd0, 1'b0, 1'b0, 6'h00, 25'h0);
        chk("cmo_write_ok", 64'h1, 64'(cmo_write_ok));
        insn_stage2_access_perm1 = 1'b0;
        acc(1'b1, 2'd2, 64'h0, 3'h0, 64'h0);
        ins(2'd0, 2'd1, 1'b0, 1'b0, 6'h00, 25'h0);
        $display("test instruction traps done");
        acc(1'b1, 2'd2, '1, 3'h0, 64'h0);
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        acc(1'b0, 2'd3, 64'h0, 3'h0, 64'h0);
        $display("test second reset done");
        test_done();
    end
endmodule : testbench
